// file: dv/ldc_pwm_src.sv
// Model of the external dimming source on the enable / dim pin.
// Assumes the bench sets its controls at the falling edge of mclk_i.
`timescale 1ns/1ps
module ldc_pwm_src (
    input  wire logic       mclk_i,   // Bench clock
    input  wire logic       run_i,    // 1 = chop, 0 = hold level
    input  wire logic       level_i,  // Level held while idle
    input  wire logic [7:0] high_i,   // High cycles per period
    input  wire logic [7:0] low_i,    // Low cycles per period
    output logic            pin_o     // Enable / dim pin
);
    logic [7:0] cnt;
    initial
    begin
        pin_o = 1'b0;
        cnt   = 8'h00;
    end
    // Off time stays short of the missing-pulse limit while chopping
    always @(negedge mclk_i)
    begin
        if (!run_i)
        begin
            pin_o <= level_i;
            cnt   <= 8'h00;
        end
        else if (cnt + 8'h01 >= (pin_o ? high_i : low_i))
        begin
            pin_o <= ~pin_o;
            cnt   <= 8'h00;
        end
        else
            cnt <= cnt + 8'h01;
    end
endmodule : ldc_pwm_src

// file: dv/led_backlight_dimming_control_bench.sv
// Self-checking bench for the dimming control block.
// Assumes short enable, timeout and slot counts so one period is 255 cycles.
`timescale 1ns/1ps
module led_backlight_dimming_control_bench;
    import ldc_pkg::*;
    typedef struct { logic [7:0] a, d, e; } ldc_row_t;
    logic mclk = 1'b0, reset_n = 1'b0, run = 1'b0, lvl = 1'b0, pin;
    ldc_reg_req_t req = '0;
    logic [7:0] rdata, dc, node = 8'h00;
    logic [5:0] ch;
    logic       act;
    int num_errors = 0, compares = 0, c;
    ldc_row_t rows [4] = '{'{8'h07, 8'h80, 8'h80}, '{8'h00, 8'h40, 8'h40},
                           '{8'h02, 8'h5a, 8'h00}, '{8'h01, 8'h05, 8'h05}};
    always #4 mclk = ~mclk;
    ldc_dimming_ctrl #(.ENABLE_CYC(8), .TIMEOUT_CYC(64), .DIM_STEP_CYC(1))
    DUT (.mclk_i(mclk), .reset_n_i(reset_n), .reg_req_i(req),
         .reg_rdata_o(rdata), .enable_dim_pin_i(pin),
         .analog_dim_node_i(node), .channel_en_o(ch),
         .dc_current_o(dc), .active_o(act));
    ldc_pwm_src src (.mclk_i(mclk), .run_i(run), .level_i(lvl),
                     .high_i(8'd3), .low_i(8'd2), .pin_o(pin));
    task check(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    task tally_and_finish;
        if (num_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // One byte access per call, strobe dropped on the next falling edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk) req = '{1'b1, 1'b0, a, d};
        @(negedge mclk) req = '0;
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk) req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge mclk) req = '0;
        check(rdata, e);
    endtask : rd_chk
    // Counts on cycles over n cycles; mixed channel bits are a mismatch
    task count_on(input int n);
        c = 0;
        repeat (n)
        begin
            @(negedge mclk);
            if (ch === 6'h3f)
                c++;
            else if (ch !== 6'h00)
                check({2'b00, ch}, 8'h3f);
        end
    endtask : count_on
    task wait_cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_cyc
    // Watchdog sized well above the few thousand cycles the tests need
    initial
    begin
        #200000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        wait_cyc(16);
        reset_n = 1'b1;
        @(negedge mclk);
        check({7'h00, act}, 8'h00);
        check({2'b00, ch}, 8'h00);
        check(dc, 8'hff);
        rd_chk(8'h00, 8'hff);
        rd_chk(8'h01, 8'h01);
        rd_chk(8'h07, 8'hff);
        // Short high pulse must not wake the block
        lvl = 1'b1;
        wait_cyc(4);
        lvl = 1'b0;
        wait_cyc(12);
        check({7'h00, act}, 8'h00);
        lvl = 1'b1;
        wait_cyc(20);
        check({7'h00, act}, 8'h01);
        rd_chk(LDC_OFS_STATUS, 8'h01);
        // Plain register rows, unmapped offset among them
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        wr(LDC_OFS_DC, 8'h33);
        check(dc, 8'h33);
        // Internal duty 64/255 while the pin chops, which must not matter
        run = 1'b1;
        wait_cyc(260);
        count_on(255);
        check(c[7:0], 8'd64);
        wr(LDC_OFS_DC, 8'h00);
        count_on(255);
        check(c[7:0], 8'd0);
        wr(LDC_OFS_DC, 8'hff);
        wr(LDC_OFS_BRIGHT, 8'h00);
        count_on(255);
        check(c[7:0], 8'd0);
        // Ratio: full level times 3/5 pin duty gives 153 slots
        wr(LDC_OFS_BRIGHT, 8'hff);
        wr(LDC_OFS_METHOD, LDC_MODE_RATIO);
        wait_cyc(600);
        count_on(255);
        check(c[7:0], 8'd153);
        // External follows the pin whatever nonzero level is held
        wr(LDC_OFS_BRIGHT, 8'h40);
        wr(LDC_OFS_METHOD, LDC_MODE_EXTERNAL);
        wait_cyc(10);
        count_on(255);
        check(c[7:0], 8'd153);
        // Analog: node 25 leaves 230 slots, full node leaves none
        wr(LDC_OFS_BRIGHT, 8'hff);
        wr(LDC_OFS_METHOD, LDC_MODE_ANALOG);
        node = 8'd25;
        wait_cyc(600);
        count_on(255);
        check(c[7:0], 8'd230);
        node = 8'd255;
        wait_cyc(600);
        count_on(255);
        check(c[7:0], 8'd0);
        // Missing pulses drop to shutdown; only a new enable wakes it
        node = 8'd0;
        run = 1'b0;
        lvl = 1'b0;
        wait_cyc(80);
        check({7'h00, act}, 8'h00);
        rd_chk(LDC_OFS_STATUS, 8'h00);
        count_on(255);
        check(c[7:0], 8'd0);
        lvl = 1'b1;
        wait_cyc(20);
        check({7'h00, act}, 8'h01);
        wait_cyc(600);
        count_on(255);
        check(c[7:0], 8'd255);
        // Reset in mid-run brings every register back to its start value
        wr(LDC_OFS_DC, 8'h44);
        wr(LDC_OFS_BRIGHT, 8'h10);
        wr(LDC_OFS_METHOD, LDC_MODE_INTERNAL);
        reset_n = 1'b0;
        wait_cyc(2);
        check({2'b00, ch}, 8'h00);
        reset_n = 1'b1;
        @(negedge mclk);
        check({7'h00, act}, 8'h00);
        check(dc, 8'hff);
        rd_chk(LDC_OFS_METHOD, LDC_MODE_RATIO);
        rd_chk(LDC_OFS_BRIGHT, 8'hff);
        tally_and_finish();
    end
endmodule : led_backlight_dimming_control_bench

// file: rtl/ldc_dimming_ctrl.sv
// Dimming and enable control for a six-channel LED backlight driver.
// Assumes the serial bus engine presents register accesses on mclk_i and
// that the analog node level arrives from an on-chip converter on mclk_i.
`timescale 1ns/1ps

module ldc_dimming_ctrl
    import ldc_pkg::*;
#(
    parameter int ENABLE_CYC   = LDC_ENABLE_CYC,
    parameter int TIMEOUT_CYC  = LDC_TIMEOUT_CYC,
    parameter int DIM_STEP_CYC = LDC_DIM_STEP_CYC
)
(
    input  wire logic                  mclk_i,          // 125 MHz clock
    input  wire logic                  reset_n_i,       // Sync reset, low
    input  wire ldc_pkg::ldc_reg_req_t reg_req_i,       // Register access
    output logic [7:0]                 reg_rdata_o,     // Read data
    input  wire logic                  enable_dim_pin_i,// Enable/dim pin
    input  wire logic [7:0]            analog_dim_node_i,// Node above 0.21V
    output logic [5:0]                 channel_en_o,    // Channel chop
    output logic [7:0]                 dc_current_o,    // DC level to DACs
    output logic                       active_o         // Out of shutdown
);
    import ldc_pkg::*;

    // Counters are fixed width; refuse counts that overflow them
    if (ENABLE_CYC < 1 || ENABLE_CYC >= (1 << LDC_CNT_W))
    begin : g_bad_enable
        $error("ENABLE_CYC out of range");
    end
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (1 << LDC_CNT_W))
    begin : g_bad_timeout
        $error("TIMEOUT_CYC out of range");
    end
    if (DIM_STEP_CYC < 1 || DIM_STEP_CYC >= (1 << LDC_CNT_W))
    begin : g_bad_step
        $error("DIM_STEP_CYC out of range");
    end

    localparam logic [LDC_CNT_W-1:0] EN_LAST  = LDC_CNT_W'(ENABLE_CYC - 1);
    localparam logic [LDC_CNT_W-1:0] TO_LAST  = LDC_CNT_W'(TIMEOUT_CYC - 1);
    localparam logic [LDC_CNT_W-1:0] STP_LAST = LDC_CNT_W'(DIM_STEP_CYC - 1);
    localparam logic [7:0]           SLOT_LAST = 8'(LDC_DIM_SLOTS - 1);

    logic [7:0]           bright_q, dc_q, method_q, rdata_q;
    logic                 sync1_q, sync2_q, sync3_q, pin_q;
    ldc_state_t           state_q, state_d;
    logic [LDC_CNT_W-1:0] cnt_q, cnt_d;
    logic [LDC_CNT_W-1:0] step_cnt_q;
    logic [7:0]           slot_q, hi_acc_q, ext_duty_q, cmp_q;
    logic [5:0]           ch_q;

    // Register decode
    wire wr_bright = reg_req_i.wr && reg_req_i.addr == LDC_OFS_BRIGHT;
    wire wr_method = reg_req_i.wr && reg_req_i.addr == LDC_OFS_METHOD;
    wire wr_dc     = reg_req_i.wr && reg_req_i.addr == LDC_OFS_DC;
    wire is_active = state_q == LDC_ST_ACTIVE;
    wire [7:0] status_val = 8'(is_active) << LDC_STAT_ACTIVE_BIT;
    wire [7:0] rd_val =
        (reg_req_i.addr == LDC_OFS_BRIGHT) ? bright_q :
        (reg_req_i.addr == LDC_OFS_METHOD) ? method_q :
        (reg_req_i.addr == LDC_OFS_DC)     ? dc_q     :
        (reg_req_i.addr == LDC_OFS_STATUS) ? status_val : 8'h00;

    // Register file; DC level takes effect on the clock after the write
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            bright_q <= LDC_RST_BRIGHT;
            dc_q     <= LDC_RST_DC;
            method_q <= LDC_RST_METHOD;
            rdata_q  <= 8'h00;
        end
        else
        begin
            if (wr_bright) bright_q <= reg_req_i.wdata;
            if (wr_dc)     dc_q     <= reg_req_i.wdata;
            if (wr_method) method_q <= reg_req_i.wdata;
            if (reg_req_i.rd) rdata_q <= rd_val;
        end
    end

    // Pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            pin_q   <= 1'b0;
        end
        else
        begin
            sync1_q <= enable_dim_pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) pin_q <= sync3_q;
        end
    end

    // Enable qualification and missing-pulse timeout share one counter
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            LDC_ST_SHUT:
            begin
                if (!pin_q)
                    cnt_d = '0;
                else if (cnt_q == EN_LAST)
                begin
                    state_d = LDC_ST_ACTIVE;
                    cnt_d   = '0;
                end
                else
                    cnt_d = cnt_q + 1'b1;
            end
            LDC_ST_ACTIVE:
            begin
                if (pin_q)
                    cnt_d = '0;
                else if (cnt_q == TO_LAST)
                begin
                    state_d = LDC_ST_SHUT;
                    cnt_d   = '0;
                end
                else
                    cnt_d = cnt_q + 1'b1;
            end
            default:
            begin
                state_d = LDC_ST_SHUT;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= LDC_ST_SHUT;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Internal dimming oscillator: slot enable and 255-slot period
    wire step_en  = step_cnt_q == STP_LAST;
    wire wrap     = step_en && slot_q == SLOT_LAST;

    // Ratiometric and analog factors; scale() gives x*y/255 rounded down
    function automatic logic [7:0] scale(input logic [7:0] a,
                                         input logic [7:0] b);
        logic [15:0] p;
        logic [15:0] s;
        p = 16'(a) * 16'(b);
        s = p + {8'h00, p[15:8]} + 16'h0001;
        return s[15:8];
    endfunction : scale

    wire [7:0] ext_now  = hi_acc_q + {7'h00, pin_q};
    wire [7:0] ana_fac  = 8'hff - analog_dim_node_i;
    wire is_analog      = method_q == LDC_MODE_ANALOG;
    wire [7:0] cmp_next = is_analog ? scale(bright_q, ana_fac)
                                    : scale(bright_q, ext_duty_q);

    // Period timing; ext duty is pin samples per period, so the pin
    // must run several times faster than the dimming rate
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            step_cnt_q <= '0;
            slot_q     <= 8'h00;
            hi_acc_q   <= 8'h00;
            ext_duty_q <= 8'hff;
            cmp_q      <= 8'hff;
        end
        else
        begin
            step_cnt_q <= step_en ? '0 : step_cnt_q + 1'b1;
            if (wrap)
            begin
                slot_q     <= 8'h00;
                hi_acc_q   <= 8'h00;
                ext_duty_q <= ext_now;
                cmp_q      <= cmp_next;
            end
            else if (step_en)
            begin
                slot_q   <= slot_q + 8'h01;
                hi_acc_q <= ext_now;
            end
        end
    end

    // Chop source selection; unknown codes behave as ratiometric
    wire is_int   = method_q == LDC_MODE_INTERNAL;
    wire is_ext   = method_q == LDC_MODE_EXTERNAL;
    wire int_on   = slot_q < bright_q;
    wire prod_on  = slot_q < cmp_q;
    // External duty range comes from the stage's own min on/off times
    wire src_on   = is_int ? int_on :
                    is_ext ? pin_q  : prod_on;
    wire chop_d   = is_active && dc_q != 8'h00 &&
                    bright_q != 8'h00 && src_on;

    // One waveform fans out to all channels
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
            ch_q <= 6'h00;
        else
            ch_q <= {6{chop_d}};
    end

    assign reg_rdata_o  = rdata_q;
    assign channel_en_o = ch_q;
    assign dc_current_o = dc_q;
    assign active_o     = state_q[1];                     // One-hot active bit

    // Checks
    sequence s_timeout;
        is_active && !pin_q && cnt_q == TO_LAST;
    endsequence

    sequence s_qualify;
        !is_active && pin_q && cnt_q == EN_LAST;
    endsequence

    chk_enable_qualify: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) s_qualify |=> is_active)
        else $error("qualified pulse did not enable");

    chk_timeout_shut: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        s_timeout |=> !is_active ##1 channel_en_o == 6'h00)
        else $error("timeout did not shut down");

    chk_stays_off: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        !is_active && !pin_q |=> !is_active ##1 channel_en_o == 6'h00)
        else $error("channels on while in shutdown");

    chk_dc_live_write: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        wr_dc |=> dc_current_o == $past(reg_req_i.wdata))
        else $error("DC level write not applied");

    chk_dc_reset: assert property (@(posedge mclk_i)
        $rose(reset_n_i) |-> dc_q == 8'hff && bright_q == 8'hff)
        else $error("levels wrong after reset");

    chk_method_reset: assert property (@(posedge mclk_i)
        $rose(reset_n_i) |-> method_q == LDC_MODE_RATIO)
        else $error("method not ratiometric after reset");

    chk_dc_zero_off: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) dc_q == 8'h00 |=> channel_en_o == 6'h00)
        else $error("channel on with zero DC level");

    chk_bright_zero_off: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) bright_q == 8'h00 |=> channel_en_o == 6'h00)
        else $error("channel on with zero PWM level");

    chk_common_chop: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        channel_en_o == 6'h00 || channel_en_o == 6'h3f)
        else $error("channels not chopped together");

    chk_ext_follow: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        is_ext && is_active && dc_q != 8'h00 && bright_q != 8'h00
        |=> channel_en_o == {6{$past(pin_q)}})
        else $error("external mode not following pin");

    chk_int_duty: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        is_int && is_active && dc_q != 8'h00 && bright_q != 8'h00
        |=> channel_en_o == {6{$past(slot_q) < $past(bright_q)}})
        else $error("internal duty wrong");

    sequence s_slot_step;
        step_en && !wrap;
    endsequence

    chk_slot_advance: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        s_slot_step |=> slot_q == $past(slot_q) + 8'h01)
        else $error("slot did not advance");

    chk_slot_wrap: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        wrap |=> slot_q == 8'h00 && hi_acc_q == 8'h00)
        else $error("period did not restart");

    // Full level must pass the measured pin duty through unchanged
    chk_ratio_full: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        wrap && !is_analog && bright_q == 8'hff
        |=> cmp_q == $past(ext_duty_q))
        else $error("full level ratio differs from pin duty");

    chk_analog_dark: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        wrap && is_analog && analog_dim_node_i == 8'hff |=> cmp_q == 8'h00)
        else $error("full node level did not darken");

    chk_analog_full: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        wrap && is_analog && analog_dim_node_i == 8'h00 && bright_q == 8'hff
        |=> cmp_q == 8'hff)
        else $error("zero node level did not give full duty");

    chk_bright_write: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        wr_bright |=> bright_q == $past(reg_req_i.wdata))
        else $error("PWM level write not applied");

    // A read returns the level held before any same-cycle write
    chk_read_old: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        reg_req_i.rd && reg_req_i.addr == LDC_OFS_DC
        |=> reg_rdata_o == $past(dc_q))
        else $error("DC level read back wrong");

    chk_rdata_hold: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        !reg_req_i.rd |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");

    // Pin level moves only when two synchroniser stages agree
    chk_pin_agree: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        $changed(pin_q) |-> $past(sync2_q) == $past(sync3_q))
        else $error("pin level taken before stages agreed");

endmodule : ldc_dimming_ctrl

// file: rtl/ldc_pkg.sv
// Constants and carrier types for the backlight dimming control block.
// Assumes a single 125 MHz clock and a byte-wide register port.
package ldc_pkg;

    // Register offsets
    localparam logic [7:0] LDC_OFS_BRIGHT  = 8'h00;
    localparam logic [7:0] LDC_OFS_METHOD  = 8'h01;
    localparam logic [7:0] LDC_OFS_DC      = 8'h07;
    localparam logic [7:0] LDC_OFS_STATUS  = 8'h0a;

    // Values after reset
    localparam logic [7:0] LDC_RST_BRIGHT  = 8'hff;
    localparam logic [7:0] LDC_RST_DC      = 8'hff;
    localparam logic [7:0] LDC_RST_METHOD  = 8'h01;

    // Dimming method codes
    localparam logic [7:0] LDC_MODE_RATIO    = 8'h01;
    localparam logic [7:0] LDC_MODE_EXTERNAL = 8'h03;
    localparam logic [7:0] LDC_MODE_INTERNAL = 8'h05;
    localparam logic [7:0] LDC_MODE_ANALOG   = 8'h07;

    // Status field position
    localparam int LDC_STAT_ACTIVE_BIT = 0;

    // Timing
    localparam int LDC_CLK_PERIOD_PS  = 8000;
    localparam int LDC_ENABLE_MIN_NS  = 40000;
    localparam int LDC_TIMEOUT_MS     = 28;
    localparam int LDC_ENABLE_CYC     =
        (LDC_ENABLE_MIN_NS * 1000 + LDC_CLK_PERIOD_PS - 1) / LDC_CLK_PERIOD_PS;
    localparam int LDC_TIMEOUT_CYC    =
        (LDC_TIMEOUT_MS * 1000000) / (LDC_CLK_PERIOD_PS / 1000);

    // Clocks per slot of the internal dimming period (200 Hz default)
    localparam int LDC_DIM_STEP_CYC   = 2450;
    localparam int LDC_DIM_SLOTS      = 255;
    localparam int LDC_CNT_W          = 22;

    // Register access request from the serial bus engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ldc_reg_req_t;

    // Enable state machine
    typedef enum logic [1:0] {
        LDC_ST_SHUT   = 2'b01,
        LDC_ST_ACTIVE = 2'b10
    } ldc_state_t;

endpackage : ldc_pkg
